/* verilog/probe_trigger_pkg.sv */
package probe_trigger_pkg;

  // Structural defaults
  localparam int NUM_PROBES_DEF = 4;
  localparam int PROBE_W_DEF = 8;
  localparam int SEQ_STATES_DEF = 16;
  localparam int NUM_CNT_DEF = 4;
  localparam int NUM_FLAG_DEF = 4;
  localparam int CNT_W_DEF = 16;
  localparam int NUM_BRANCH = 3;
  localparam int CODE_W = 3;
  localparam int ADDR_W = 12;
  localparam int BR_W = 19;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_PROBE_BASE = 12'h010;
  localparam logic [ADDR_W-1:0] PROBE_STRIDE = 12'h008;
  localparam logic [ADDR_W-1:0] PROBE_CTRL_OFS = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_LIMIT_BASE = 12'h080;
  localparam logic [ADDR_W-1:0] OFF_COUNT_BASE = 12'h0A0;
  localparam logic [3:0] OFF_PROG_PAGE = 4'h1;

  // Field positions
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_FUNC_LSB = 3;
  localparam int PCTL_OP_LSB = 0;
  localparam int PCTL_SIGNED_BIT = 3;
  localparam int PCTL_PART_BIT = 4;
  localparam int STAT_TRIG_BIT = 0;
  localparam int STAT_COMB_BIT = 1;
  localparam int STAT_SEQ_BIT = 2;
  localparam int STAT_SHARED_BIT = 3;
  localparam int STAT_STATE_LSB = 4;
  localparam int STAT_FLAG_LSB = 8;
  localparam int BR_COND_LSB = 0;
  localparam int BR_INV_BIT = 4;
  localparam int BR_NEXT_LSB = 5;
  localparam int BR_VALID_BIT = 9;
  localparam int BR_TRIG_BIT = 10;
  localparam int BR_CIDX_LSB = 11;
  localparam int BR_COP_LSB = 13;
  localparam int BR_FIDX_LSB = 15;
  localparam int BR_FOP_LSB = 17;

  // Branch condition selectors above the comparator indices
  localparam logic [3:0] COND_COMBINED = 4'h8;
  localparam logic [3:0] COND_ALWAYS = 4'h9;
  localparam logic [3:0] COND_CNT_BASE = 4'hA;

  typedef enum logic [2:0] {
    plain_mode, sequencer_mode, external_edge_mode,
    plain_or_external_mode, sequencer_or_external_mode
  } trig_mode_t;
  typedef enum logic [1:0] {func_and, func_or, func_nand, func_nor} func_t;
  typedef enum logic [2:0] {op_eq, op_ne, op_lt, op_le, op_gt, op_ge} cmp_op_t;
  typedef enum logic [2:0] {
    code_low, code_high, code_dont_care, code_rise, code_fall, code_both, code_no_change
  } bit_code_t;
  typedef enum logic [1:0] {cnt_none, cnt_inc, cnt_clear} cnt_op_t;
  typedef enum logic [1:0] {flag_none, flag_set, flag_clear} flag_op_t;

  // Reset values and highest accepted mode and operator codes
  localparam trig_mode_t MODE_RST = plain_mode;
  localparam func_t FUNC_RST = func_and;
  localparam cmp_op_t OP_RST = op_eq;
  localparam logic [2:0] MODE_MAX = 3'h4;
  localparam logic [2:0] OP_MAX = 3'h5;
  localparam logic [31:0] CODE_RST = 32'h00492492;
  localparam logic [31:0] LIMIT_RST = 32'h00000000;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        r[8*i+:8] = d[8*i+:8];
    end
    return r;
  endfunction

endpackage

/* verilog/seq_program_mem.sv */
`timescale 1ns/1ns
module seq_program_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
)(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [DEPTH-1:0] valid_reg;

  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  // Unwritten entries read as zero so an unprogrammed state never branches
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      valid_reg <= '0;
    else if (wr_en)
      valid_reg[wr_addr] <= 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rd_data <= '0;
    else if (valid_reg[rd_addr])
      rd_data <= mem[rd_addr];
    else
      rd_data <= '0;
  end

endmodule

/* verilog/probe_trigger_compare.sv */
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
// Function
// - Plain comparison only in its two modes
// - Unselected probes never affect combined condition
// - Six relational operators per comparator
// - Rise, fall, both edge bit codes
// - No-change code needs equal consecutive samples
// - Ignored hex or octal digits mask bits
// - Magnitude compare honours chosen signedness
// - Global AND, OR, NAND, NOR combination
// - Shared port allows only AND, NAND
// - Sequencer exists only when parameter enables
// - Sequencer program up to sixteen states
// - One, two or three branches per state
// - Up to four event counters
// - Up to four branch flags
// - Actions jump, trigger, counter, flag operations
// - Sequencer replaces combination in its modes
// - External edge mode, ORed external modes
module probe_trigger_compare
  import probe_trigger_pkg::*;
#(
  parameter int NUM_PROBES = NUM_PROBES_DEF,
  parameter int PROBE_W = PROBE_W_DEF,
  parameter int SEQ_STATES = SEQ_STATES_DEF,
  parameter int NUM_CNT = NUM_CNT_DEF,
  parameter int NUM_FLAG = NUM_FLAG_DEF,
  parameter int CNT_W = CNT_W_DEF,
  parameter bit SEQ_EN = 1'b1,
  parameter bit SHARED_PORT = 1'b0
)(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [NUM_PROBES*PROBE_W-1:0] probe_in,
  input wire logic external_trigger_input,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic trigger_out
);

  localparam int SW = $clog2(SEQ_STATES);
  localparam int CW = CODE_W * PROBE_W;

  trig_mode_t mode_reg;
  func_t func_reg;
  cmp_op_t op_reg [NUM_PROBES];
  logic [NUM_PROBES-1:0] signed_reg;
  logic [NUM_PROBES-1:0] part_reg;
  logic [CW-1:0] code_reg [NUM_PROBES];
  logic [CNT_W-1:0] limit_reg [NUM_CNT];
  logic [CNT_W-1:0] cnt_reg [NUM_CNT];
  logic [NUM_FLAG-1:0] flag_reg;
  logic [SW-1:0] state_reg;
  logic [SW-1:0] state_next;
  logic [NUM_PROBES*PROBE_W-1:0] probe_prev_reg;
  logic ext_prev_reg;
  logic comb_reg;
  logic comb_now;
  logic seq_trig;
  logic seq_active;
  logic trig_next;
  logic [NUM_PROBES-1:0] cmp_hit;
  logic [NUM_CNT-1:0] cnt_hit;
  logic wr_stb;
  logic rd_stb;
  logic [31:0] rd_word;

  assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign rd_stb = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
  assign seq_active = (mode_reg == sequencer_mode) || (mode_reg == sequencer_or_external_mode);

  // Bus slave: one wait state, ack for one cycle, unmapped reads as zero
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      wb_dat_o <= 32'h00000000;
    else if (rd_stb)
      wb_dat_o <= rd_word;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      mode_reg <= MODE_RST;
      func_reg <= FUNC_RST;
    end
    else if (wr_stb && wb_adr_i == OFF_CONTROL && wb_sel_i[0])
    begin
      if (wb_dat_i[CTL_MODE_LSB+:3] <= MODE_MAX)
        mode_reg <= trig_mode_t'(wb_dat_i[CTL_MODE_LSB+:3]);
      // A shared port cannot build OR or NOR, so such writes leave the function as it was
      if (!SHARED_PORT || wb_dat_i[CTL_FUNC_LSB] == 1'b0)
        func_reg <= func_t'(wb_dat_i[CTL_FUNC_LSB+:2]);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    for (int p = 0; p < NUM_PROBES; p++)
    begin
      if (rst)
      begin
        code_reg[p] <= CODE_RST[CW-1:0];
        op_reg[p] <= OP_RST;
        signed_reg[p] <= 1'b0;
        part_reg[p] <= 1'b0;
      end
      else if (wr_stb && wb_adr_i == OFF_PROBE_BASE + ADDR_W'(p) * PROBE_STRIDE)
        code_reg[p] <= CW'(wmerge(32'(code_reg[p]), wb_dat_i, wb_sel_i));
      else if (wr_stb && wb_sel_i[0] &&
               wb_adr_i == OFF_PROBE_BASE + ADDR_W'(p) * PROBE_STRIDE + PROBE_CTRL_OFS)
      begin
        if (wb_dat_i[PCTL_OP_LSB+:3] <= OP_MAX)
          op_reg[p] <= cmp_op_t'(wb_dat_i[PCTL_OP_LSB+:3]);
        signed_reg[p] <= wb_dat_i[PCTL_SIGNED_BIT];
        part_reg[p] <= wb_dat_i[PCTL_PART_BIT];
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    for (int k = 0; k < NUM_CNT; k++)
    begin
      if (rst)
        limit_reg[k] <= LIMIT_RST[CNT_W-1:0];
      else if (wr_stb && wb_adr_i == OFF_LIMIT_BASE + ADDR_W'(4 * k))
        limit_reg[k] <= CNT_W'(wmerge(32'(limit_reg[k]), wb_dat_i, wb_sel_i));
    end
  end

  always_comb
  begin
    rd_word = 32'h00000000;
    if (wb_adr_i == OFF_CONTROL)
    begin
      rd_word[CTL_MODE_LSB+:3] = mode_reg;
      rd_word[CTL_FUNC_LSB+:2] = func_reg;
    end
    if (wb_adr_i == OFF_STATUS)
    begin
      rd_word[STAT_TRIG_BIT] = trigger_out;
      rd_word[STAT_COMB_BIT] = comb_reg;
      rd_word[STAT_SEQ_BIT] = SEQ_EN;
      rd_word[STAT_SHARED_BIT] = SHARED_PORT;
      rd_word[STAT_STATE_LSB+:SW] = state_reg;
      rd_word[STAT_FLAG_LSB+:NUM_FLAG] = flag_reg;
    end
    for (int p = 0; p < NUM_PROBES; p++)
    begin
      if (wb_adr_i == OFF_PROBE_BASE + ADDR_W'(p) * PROBE_STRIDE)
        rd_word = 32'(code_reg[p]);
      if (wb_adr_i == OFF_PROBE_BASE + ADDR_W'(p) * PROBE_STRIDE + PROBE_CTRL_OFS)
      begin
        rd_word[PCTL_OP_LSB+:3] = op_reg[p];
        rd_word[PCTL_SIGNED_BIT] = signed_reg[p];
        rd_word[PCTL_PART_BIT] = part_reg[p];
      end
    end
    for (int k = 0; k < NUM_CNT; k++)
    begin
      if (wb_adr_i == OFF_LIMIT_BASE + ADDR_W'(4 * k))
        rd_word = 32'(limit_reg[k]);
      if (wb_adr_i == OFF_COUNT_BASE + ADDR_W'(4 * k))
        rd_word = 32'(cnt_reg[k]);
    end
  end

  // History of every probe bit for edge and no-change codes
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      probe_prev_reg <= '0;
      ext_prev_reg <= 1'b0;
    end
    else
    begin
      probe_prev_reg <= probe_in;
      ext_prev_reg <= external_trigger_input;
    end
  end

  for (genvar p = 0; p < NUM_PROBES; p++)
  begin : g_cmp
    logic [PROBE_W-1:0] care;
    logic [PROBE_W-1:0] lvl;
    logic [PROBE_W-1:0] edge_ok;
    logic [PROBE_W-1:0] cur;
    logic [PROBE_W-1:0] prv;
    logic lt;
    logic eq;
    logic rel;

    assign cur = probe_in[p*PROBE_W+:PROBE_W];
    assign prv = probe_prev_reg[p*PROBE_W+:PROBE_W];

    always_comb
    begin
      care = '0;
      lvl = '0;
      edge_ok = '0;
      for (int b = 0; b < PROBE_W; b++)
      begin
        // Only level codes take part in the magnitude; ignore codes drop the bit
        care[b] = (code_reg[p][CODE_W*b+:CODE_W] == code_low) ||
                  (code_reg[p][CODE_W*b+:CODE_W] == code_high);
        lvl[b] = (code_reg[p][CODE_W*b+:CODE_W] == code_high);
        case (bit_code_t'(code_reg[p][CODE_W*b+:CODE_W]))
          code_rise: edge_ok[b] = ~prv[b] & cur[b];
          code_fall: edge_ok[b] = prv[b] & ~cur[b];
          code_both: edge_ok[b] = prv[b] ^ cur[b];
          code_no_change: edge_ok[b] = ~(prv[b] ^ cur[b]);
          default: edge_ok[b] = 1'b1;
        endcase
      end
    end

    always_comb
    begin
      eq = (cur & care) == (lvl & care);
      if (signed_reg[p])
        lt = $signed(cur & care) < $signed(lvl & care);
      else
        lt = (cur & care) < (lvl & care);
      case (op_reg[p])
        op_eq: rel = eq;
        op_ne: rel = ~eq;
        op_lt: rel = lt;
        op_le: rel = lt | eq;
        op_gt: rel = ~lt & ~eq;
        op_ge: rel = ~lt;
        default: rel = 1'b0;
      endcase
    end

    assign cmp_hit[p] = rel & (&edge_ok);
  end

  always_comb
  begin
    case (func_reg)
      func_and: comb_now = &(cmp_hit | ~part_reg);
      func_or: comb_now = |(cmp_hit & part_reg);
      func_nand: comb_now = ~&(cmp_hit | ~part_reg);
      func_nor: comb_now = ~|(cmp_hit & part_reg);
      default: comb_now = 1'b0;
    endcase
  end

  always_comb
  begin
    case (mode_reg)
      plain_mode: trig_next = comb_now;
      sequencer_mode: trig_next = seq_trig;
      external_edge_mode: trig_next = external_trigger_input & ~ext_prev_reg;
      plain_or_external_mode: trig_next = comb_now | external_trigger_input;
      sequencer_or_external_mode: trig_next = seq_trig | external_trigger_input;
      default: trig_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      comb_reg <= 1'b0;
      trigger_out <= 1'b0;
    end
    else
    begin
      comb_reg <= comb_now;
      trigger_out <= trig_next;
    end
  end

  for (genvar k = 0; k < NUM_CNT; k++)
  begin : g_hit
    assign cnt_hit[k] = cnt_reg[k] >= limit_reg[k];
  end

  if (SEQ_EN)
  begin : g_seq
    logic [BR_W-1:0] br [NUM_BRANCH];
    logic [NUM_BRANCH-1:0] br_hit;
    logic take;
    logic [1:0] tsel;
    logic [BR_W-1:0] tw;

    // Three branch memories read at the next state, so words match state_reg
    for (genvar j = 0; j < NUM_BRANCH; j++)
    begin : g_br
      logic we;
      logic c;
      logic [3:0] cs;
      assign we = wr_stb && wb_sel_i == 4'hF && wb_adr_i[11:8] == OFF_PROG_PAGE &&
                  wb_adr_i[3:2] == 2'(j) && 32'(wb_adr_i[7:4]) < SEQ_STATES;
      seq_program_mem #(.WIDTH(BR_W), .DEPTH(SEQ_STATES)) u_mem (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr_en(we),
        .wr_addr(wb_adr_i[4+:SW]),
        .wr_data(wb_dat_i[BR_W-1:0]),
        .rd_addr(state_next),
        .rd_data(br[j])
      );
      assign cs = br[j][BR_COND_LSB+:4];
      always_comb
      begin
        c = (cs == COND_ALWAYS) || (cs == COND_COMBINED && comb_now);
        for (int p = 0; p < NUM_PROBES; p++)
        begin
          if (cs == 4'(p))
            c = cmp_hit[p];
        end
        for (int k = 0; k < NUM_CNT; k++)
        begin
          if (cs == COND_CNT_BASE + 4'(k))
            c = cnt_hit[k];
        end
      end
      assign br_hit[j] = br[j][BR_VALID_BIT] & (c ^ br[j][BR_INV_BIT]);
    end

    // Lowest numbered true branch wins
    always_comb
    begin
      take = 1'b0;
      tsel = 2'h0;
      for (int j = NUM_BRANCH - 1; j >= 0; j--)
      begin
        if (br_hit[j])
        begin
          take = 1'b1;
          tsel = 2'(j);
        end
      end
    end

    assign tw = br[tsel];
    assign seq_trig = take & tw[BR_TRIG_BIT];
    assign state_next = !seq_active ? '0 : take ? tw[BR_NEXT_LSB+:SW] : state_reg;

    always_ff @(posedge clk_sys)
    begin
      if (rst)
        state_reg <= '0;
      else
        state_reg <= state_next;
    end

    // Counters saturate so a long run cannot wrap back under the limit
    always_ff @(posedge clk_sys)
    begin
      for (int k = 0; k < NUM_CNT; k++)
      begin
        if (rst || !seq_active)
          cnt_reg[k] <= '0;
        else if (take && tw[BR_CIDX_LSB+:2] == 2'(k))
        begin
          if (tw[BR_COP_LSB+:2] == cnt_inc && cnt_reg[k] != '1)
            cnt_reg[k] <= cnt_reg[k] + CNT_W'(1);
          else if (tw[BR_COP_LSB+:2] == cnt_clear)
            cnt_reg[k] <= '0;
        end
      end
    end

    always_ff @(posedge clk_sys)
    begin
      for (int f = 0; f < NUM_FLAG; f++)
      begin
        if (rst || !seq_active)
          flag_reg[f] <= 1'b0;
        else if (take && tw[BR_FIDX_LSB+:2] == 2'(f))
        begin
          if (tw[BR_FOP_LSB+:2] == flag_set)
            flag_reg[f] <= 1'b1;
          else if (tw[BR_FOP_LSB+:2] == flag_clear)
            flag_reg[f] <= 1'b0;
        end
      end
    end
  end
  else
  begin : g_noseq
    assign seq_trig = 1'b0;
    assign state_next = '0;
    assign state_reg = '0;
    assign flag_reg = '0;
    for (genvar k = 0; k < NUM_CNT; k++)
    begin : g_c
      assign cnt_reg[k] = '0;
    end
  end

  AST_EXT_EDGE: assert property (@(posedge clk_sys) disable iff (rst)
    mode_reg == external_edge_mode && external_trigger_input && !ext_prev_reg |=> trigger_out)
    else $error("external rising edge did not fire trigger");
  AST_EXT_STEADY: assert property (@(posedge clk_sys) disable iff (rst)
    mode_reg == external_edge_mode && ext_prev_reg |=> !trigger_out)
    else $error("trigger fired without external rising edge");
  AST_PLAIN_ONLY: assert property (@(posedge clk_sys) disable iff (rst)
    mode_reg == plain_mode |=> trigger_out == comb_reg)
    else $error("plain mode trigger differs from combined condition");
  AST_SEQ_MODE: assert property (@(posedge clk_sys) disable iff (rst)
    mode_reg == sequencer_mode && !seq_trig |=> !trigger_out)
    else $error("sequencer mode fired without sequencer action");
  AST_NONPART: assert property (@(posedge clk_sys) disable iff (rst)
    func_reg == func_and && part_reg == '0 |=> comb_reg)
    else $error("non participating probes affected AND condition");
  AST_OR_ANY: assert property (@(posedge clk_sys) disable iff (rst)
    func_reg == func_or && |(cmp_hit & part_reg) |=> comb_reg)
    else $error("OR condition missed a true comparator");
  AST_SHARED: assert property (@(posedge clk_sys) disable iff (rst)
    SHARED_PORT |-> (func_reg == func_and || func_reg == func_nand))
    else $error("shared port holds an OR or NOR function");
  AST_HISTORY: assert property (@(posedge clk_sys) disable iff (rst)
    !rst |=> probe_prev_reg == $past(probe_in))
    else $error("probe history is not the previous sample");
  AST_NOSEQ: assert property (@(posedge clk_sys) disable iff (rst)
    !SEQ_EN |-> !seq_trig && state_reg == '0)
    else $error("sequencer active though not generated");
  AST_SEQ_IDLE: assert property (@(posedge clk_sys) disable iff (rst)
    !seq_active |=> state_reg == '0 && flag_reg == '0)
    else $error("sequencer state kept outside sequencer modes");
  AST_ACK_PULSE: assert property (@(posedge clk_sys) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");

endmodule

/* test/probe_net_driver.sv */
`timescale 1ns/1ns
module probe_net_driver (
  input wire logic clk_sys,
  input wire logic [7:0] probe0_req,
  input wire logic ext_req,
  output logic [31:0] probe_in = 32'h0,
  output logic external_trigger_input = 1'b0
);
  logic [23:0] noise_reg = 24'h0;

  // Other probes change every cycle, so a leak into the condition would show
  always_ff @(posedge clk_sys)
  begin
    noise_reg <= noise_reg + 24'h010101;
    probe_in <= {noise_reg, probe0_req};
    external_trigger_input <= ext_req;
  end
endmodule

/* test/probe_trigger_compare_test.sv */
`timescale 1ns/1ns
module probe_trigger_compare_test;
  import probe_trigger_pkg::*;
  typedef struct packed {
    logic [31:0] code;
    logic [2:0] op;
    logic sgn;
    logic [7:0] prev;
    logic [7:0] cur;
    logic exp;
  } row_t;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [ADDR_W-1:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic trigger_out;
  logic trig_shared;
  logic [31:0] probe_in;
  logic external_trigger_input;
  logic [7:0] probe0_req = 8'h00;
  logic ext_req = 1'b0;
  logic [31:0] rd_val;
  int mismatches = 0;
  int total_checks = 0;
  int n;
  // Value 0x05 on probe 0; upper fields 2 mean ignored bits
  row_t rows [19] = '{
    '{32'h41, op_eq, 1'b0, 8'h00, 8'h05, 1'b1}, '{32'h41, op_eq, 1'b0, 8'h00, 8'h06, 1'b0},
    '{32'h41, op_ne, 1'b0, 8'h00, 8'h06, 1'b1}, '{32'h41, op_lt, 1'b0, 8'h00, 8'h04, 1'b1},
    '{32'h41, op_lt, 1'b0, 8'h00, 8'h05, 1'b0}, '{32'h41, op_le, 1'b0, 8'h00, 8'h05, 1'b1},
    '{32'h41, op_gt, 1'b0, 8'h00, 8'h06, 1'b1}, '{32'h41, op_gt, 1'b0, 8'h00, 8'h05, 1'b0},
    '{32'h41, op_ge, 1'b0, 8'h00, 8'h05, 1'b1}, '{32'h41, op_lt, 1'b1, 8'h00, 8'hF0, 1'b1},
    '{32'h41, op_lt, 1'b0, 8'h00, 8'hF0, 1'b0}, '{32'h492041, op_eq, 1'b0, 8'h00, 8'hA5, 1'b1},
    '{32'h492493, op_eq, 1'b0, 8'h00, 8'h01, 1'b1}, '{32'h492493, op_eq, 1'b0, 8'h01, 8'h01, 1'b0},
    '{32'h492494, op_eq, 1'b0, 8'h01, 8'h00, 1'b1}, '{32'h492495, op_eq, 1'b0, 8'h00, 8'h01, 1'b1},
    '{32'h492495, op_eq, 1'b0, 8'h01, 8'h00, 1'b1}, '{32'h492496, op_eq, 1'b0, 8'h01, 8'h01, 1'b1},
    '{32'h492496, op_eq, 1'b0, 8'h00, 8'h01, 1'b0}
  };

  always #4 clk_sys = ~clk_sys;

  probe_trigger_compare uut (
    .clk_sys(clk_sys), .rst(rst), .probe_in(probe_in),
    .external_trigger_input(external_trigger_input),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .trigger_out(trigger_out)
  );

  // Shared-port build without sequencer sees the same bus writes
  probe_trigger_compare #(.SEQ_EN(1'b0), .SHARED_PORT(1'b1)) uut_shared (
    .clk_sys(clk_sys), .rst(rst), .probe_in(probe_in),
    .external_trigger_input(external_trigger_input),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(), .wb_ack_o(),
    .trigger_out(trig_shared)
  );

  probe_net_driver partner (
    .clk_sys(clk_sys), .probe0_req(probe0_req), .ext_req(ext_req),
    .probe_in(probe_in), .external_trigger_input(external_trigger_input)
  );

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Entered just after a rising edge; waits for ack, never a fixed count
  task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] dat,
                    output logic [31:0] rd);
    int k;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hF;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (k >= 20)
    begin
      mismatches++;
      test_done();
    end
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [11:0] adr, input logic [31:0] dat);
    logic [31:0] x;
    wb(1'b1, adr, dat, x);
  endtask

  task automatic trig_after(input int edges, input logic exp);
    repeat (edges) @(posedge clk_sys);
    chk({31'h0, trigger_out}, {31'h0, exp});
  endtask

  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    wb(1'b0, OFF_CONTROL, 32'h0, rd_val);
    chk(rd_val, 32'h0);
    foreach (rows[i])
    begin
      wr(12'h010, rows[i].code);
      wr(12'h014, {27'h0, 1'b1, rows[i].sgn, rows[i].op});
      probe0_req <= rows[i].prev;
      @(posedge clk_sys);
      probe0_req <= rows[i].cur;
      trig_after(3, rows[i].exp);
    end
    wr(12'h010, 32'h41);
    wr(12'h014, 32'h10);
    wr(12'h018, 32'h492492);
    wr(12'h01C, 32'h10);
    probe0_req <= 8'h06;
    for (int f = 0; f < 4; f++)
    begin
      wr(OFF_CONTROL, 32'(f) << 3);
      trig_after(2, 1'(4'b0110 >> f));
      chk({31'h0, trig_shared}, {31'h0, 1'(4'b1100 >> f)});
    end
    wr(12'h01C, 32'h00);
    trig_after(2, 1'b1);
    wr(OFF_CONTROL, 32'h0);
    probe0_req <= 8'h05;
    wr(OFF_CONTROL, 32'h1);
    trig_after(3, 1'b0);
    wr(OFF_CONTROL, 32'h2);
    trig_after(2, 1'b0);
    ext_req <= 1'b1;
    trig_after(3, 1'b1);
    trig_after(1, 1'b0);
    probe0_req <= 8'h06;
    wr(OFF_CONTROL, 32'h3);
    trig_after(3, 1'b1);
    ext_req <= 1'b0;
    trig_after(3, 1'b0);
    probe0_req <= 8'h05;
    wr(12'h100, 32'h229);
    wr(12'h110, 32'h2A620);
    wr(OFF_CONTROL, 32'h1);
    n = 0;
    while (trigger_out !== 1'b1 && n < 10)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk({31'h0, trigger_out}, 32'h1);
    if (n >= 10)
      test_done();
    chk({31'h0, trig_shared}, 32'h0);
    wb(1'b0, OFF_STATUS, 32'h0, rd_val);
    chk(rd_val & 32'hFFC, 32'h214);
    wb(1'b0, OFF_COUNT_BASE, 32'h0, rd_val);
    chk({31'h0, rd_val != 32'h0}, 32'h1);
    wb(1'b0, 12'h7F0, 32'h0, rd_val);
    chk(rd_val, 32'h0);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    trig_after(1, 1'b0);
    wb(1'b0, OFF_CONTROL, 32'h0, rd_val);
    chk(rd_val, 32'h0);
    test_done();
  end
endmodule
